// ==== core/dead_time_gate.v ====
// per-bit turn-on delay: a request rising to 1 reaches the output after the dead time
`timescale 1ns/10ps
`include "hb_ctrl_map.vh"
module dead_time_gate #(
   parameter N = 12,
   parameter DEAD_CYCLES = `DEAD_CYC,
   parameter CW = 12
) (
   input wire clk_sys_i,
   input wire reset_n_i,
   input wire [N-1:0] req_i,
   output reg [N-1:0] out_o
);
   reg [CW-1:0] cnt_ff [0:N-1];
   integer i;

   // turn-off passes at once, turn-on waits so both switches are never on together
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         out_o <= {N{1'b0}};
         for (i = 0; i < N; i = i + 1) begin
            cnt_ff[i] <= {CW{1'b0}};
         end
      end else begin
         for (i = 0; i < N; i = i + 1) begin
            if (!req_i[i]) begin
               out_o[i] <= 1'b0;
               cnt_ff[i] <= {CW{1'b0}};
            end else if (!out_o[i]) begin
               if (cnt_ff[i] >= DEAD_CYCLES[CW-1:0] - 1'b1) begin
                  out_o[i] <= 1'b1;
               end else begin
                  cnt_ff[i] <= cnt_ff[i] + 1'b1;
               end
            end
         end
      end
   end
endmodule // dead_time_gate

// ==== core/hb_ctrl_map.vh ====
// register map, field positions, reset values and timing counts of the half-bridge controller
`ifndef HB_CTRL_MAP_VH
`define HB_CTRL_MAP_VH
// register addresses (5-bit header field)
`define ADDR_RESET_STATUS 5'h0f
`define ADDR_BRIDGE_CTRL 5'h0e
`define ADDR_PWM_SELECT 5'h0d
`define ADDR_SYS_STATUS 5'h0c
`define ADDR_BRIDGE_STATUS 5'h0b
`define ADDR_SYS_CTRL 5'h0a
// header byte layout
`define HDR_RW_BIT 7
`define HDR_ADDR_MSB 6
`define HDR_ADDR_LSB 2
`define HDR_PARITY_BIT 1
// reset values
`define BRIDGE_CTRL_RST 16'h0000
`define PWM_SELECT_RST 8'h00
`define SYS_CTRL_RST 8'h00
`define STATUS_RST 8'h00
// field positions
`define HBC_FIRST_BIT 4
`define PWM_SELECT_REG_FIRST_BIT 2
`define SC_OC_SCOPE_BIT 0
`define SS_OC13_BIT 6
`define SS_OC46_BIT 5
`define SS_OT_BIT 2
`define SS_PE_BIT 1
`define RS_EXT_BIT 6
// timing
`define CLK_PERIOD_NS 8
`define DEAD_TIME_NS 1000
`define DEAD_CYC ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== core/spi_half_bridge_control.v ====
// serial register slave and six-channel half-bridge output control
`timescale 1ns/10ps
`include "hb_ctrl_map.vh"
////////////////////////////////////////////////////////////////////////////////
// Function
// - registers drive outputs only when sleep, inhibit high
// - pwm input drives selected low-side switches
// - inhibit falling clears control and pwm select
// - bridge control and pwm select writes ignored while inhibit low
// - sleep holds low-side outputs as before entry
// - high-side on at sleep entry gives high-z
// - inhibit mode: all outputs off high-z
// - over-current forces affected outputs off while awake; held low sides stay on in sleep
// - scope 0, channels 1-3 clear own bits
// - scope 0, channels 4-6 clear own bits
// - scope 1, any over-current clears everything
// - over-current reported in status registers
// - new turn-on delayed by dead time, except pwm-driven low sides
// - 8-bit units, msb first
// - transfer only while slave select low
// - shift out on rise, sample on fall
// - write header checked for even parity
// - parity error flags and suppresses write
// - good write commits at slave select rise
// - read header gets no parity check
// - serial interface halted while sleep low
// - pair encoding off, low, high; both prohibited
// - write setting both bits keeps the pair
// - overheat blocks bridge control writes
module spi_half_bridge_control #(
   parameter DEAD_CYCLES = `DEAD_CYC
) (
   input wire clk_sys_i,
   input wire reset_n_i,
   input wire sleep_control_pin_i,
   input wire inhibit_pin_i,
   input wire pwm_input_pin_i,
   input wire overheat_i,
   input wire [5:0] overcurrent_i,
   input wire ext_reset_seen_i,
   input wire slave_select_input_n_i,
   input wire serial_clock_input_i,
   input wire serial_data_in_i,
   output reg serial_data_out_o,
   output reg serial_data_out_oe_n_o,
   output reg [5:0] high_side_on_o,
   output reg [5:0] low_side_on_o,
   output reg [5:0] bridge_output_hiz_o
);
   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers
   reg [1:0] slp_s_ff, inh_s_ff, pwm_s_ff, ot_s_ff, ers_s_ff;
   reg [1:0] ss_s_ff, sck_s_ff, sdi_s_ff;
   reg [5:0] oc_a_ff, oc_b_ff;
   reg ss_d_ff, sck_d_ff;

   // two flops on every pin before logic looks at it
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         slp_s_ff <= 2'h0;
         inh_s_ff <= 2'h0;
         pwm_s_ff <= 2'h0;
         ot_s_ff <= 2'h0;
         ers_s_ff <= 2'h0;
         ss_s_ff <= 2'h3;
         // serial clock idles high, so reset to that level to avoid a false edge
         sck_s_ff <= 2'h3;
         sdi_s_ff <= 2'h0;
         oc_a_ff <= 6'h00;
         oc_b_ff <= 6'h00;
         ss_d_ff <= 1'b1;
         sck_d_ff <= 1'b1;
      end else begin
         slp_s_ff <= {slp_s_ff[0], sleep_control_pin_i};
         inh_s_ff <= {inh_s_ff[0], inhibit_pin_i};
         pwm_s_ff <= {pwm_s_ff[0], pwm_input_pin_i};
         ot_s_ff <= {ot_s_ff[0], overheat_i};
         ers_s_ff <= {ers_s_ff[0], ext_reset_seen_i};
         ss_s_ff <= {ss_s_ff[0], slave_select_input_n_i};
         sck_s_ff <= {sck_s_ff[0], serial_clock_input_i};
         sdi_s_ff <= {sdi_s_ff[0], serial_data_in_i};
         oc_a_ff <= overcurrent_i;
         oc_b_ff <= oc_a_ff;
         ss_d_ff <= ss_s_ff[1];
         sck_d_ff <= sck_s_ff[1];
      end
   end

   wire slp = slp_s_ff[1];
   wire inhibit_pin = inh_s_ff[1];
   wire ot = ot_s_ff[1];
   wire [5:0] oc = oc_b_ff;
   wire ss_n = ss_s_ff[1];
   wire sck_rise = sck_s_ff[1] & ~sck_d_ff;
   wire sck_fall = ~sck_s_ff[1] & sck_d_ff;
   wire ss_rise = ss_s_ff[1] & ~ss_d_ff;

   ////////////////////////////////////////////////////////////////////////////
   // register storage
   reg [15:0] hbc_ff;
   reg [7:0] pwm_select_reg_ff;
   reg [7:0] sc_ff;
   reg [5:0] hbs_ff;
   reg pe_ff;
   reg ext_rst_ff;

   // serial frame state
   reg [7:0] rx_sr_ff;
   reg [7:0] hdr_ff;
   reg [7:0] d0_ff;
   reg [7:0] d1_ff;
   reg [15:0] tx_sr_ff;
   reg [2:0] bit_cnt_ff;
   reg [1:0] byte_cnt_ff;
   reg par_bad_ff;

   // even parity over r/w and address together with the parity bit
   function par_fail;
      input [7:0] h;
      begin
         par_fail = ^h[`HDR_RW_BIT:`HDR_PARITY_BIT];
      end
   endfunction

   // current value of one register, left justified in 16 bits
   function [15:0] reg_read;
      input [4:0] a;
      input [15:0] bridge_control_reg;
      input [7:0] pwm_select_reg, sc, ss, rs;
      input [5:0] bridge_status_reg;
      begin
         case (a)
            `ADDR_BRIDGE_CTRL: reg_read = bridge_control_reg;
            `ADDR_PWM_SELECT: reg_read = {pwm_select_reg, 8'h00};
            `ADDR_SYS_STATUS: reg_read = {ss, 8'h00};
            `ADDR_BRIDGE_STATUS: reg_read = {2'h0, bridge_status_reg, 8'h00};
            `ADDR_SYS_CTRL: reg_read = {sc, 8'h00};
            `ADDR_RESET_STATUS: reg_read = {rs, 8'h00};
            default: reg_read = 16'h0000;
         endcase
      end
   endfunction

   // bridge control write: a pair asked to set both bits keeps its old value
   function [15:0] hbc_merge;
      input [15:0] old;
      input [15:0] wr;
      integer k;
      begin
         hbc_merge = {wr[15:`HBC_FIRST_BIT], 4'h0};
         for (k = 0; k < 6; k = k + 1) begin
            if (wr[`HBC_FIRST_BIT + 2*k] & wr[`HBC_FIRST_BIT + 2*k + 1]) begin
               hbc_merge[`HBC_FIRST_BIT + 2*k] = old[`HBC_FIRST_BIT + 2*k];
               hbc_merge[`HBC_FIRST_BIT + 2*k + 1] = old[`HBC_FIRST_BIT + 2*k + 1];
            end
         end
      end
   endfunction

   wire oc13 = |hbs_ff[2:0];
   wire oc46 = |hbs_ff[5:3];
   wire [7:0] ss_val;
   assign ss_val = {1'b0, oc13, oc46, 2'h0, ot, pe_ff, 1'b0};
   wire [7:0] rs_val = {1'b0, ext_rst_ff, 6'h00};

   ////////////////////////////////////////////////////////////////////////////
   // serial receive and transmit
   wire [7:0] rx_next = {rx_sr_ff[6:0], sdi_s_ff[1]};
   wire byte_done = sck_fall & (bit_cnt_ff == 3'h7);

   // frame counters and shift registers; asleep or deselected means idle
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_sr_ff <= 8'h00;
         hdr_ff <= 8'h00;
         d0_ff <= 8'h00;
         d1_ff <= 8'h00;
         tx_sr_ff <= 16'h0000;
         bit_cnt_ff <= 3'h0;
         byte_cnt_ff <= 2'h0;
         par_bad_ff <= 1'b0;
         serial_data_out_o <= 1'b0;
         serial_data_out_oe_n_o <= 1'b1;
      end else if (!slp || ss_n) begin
         bit_cnt_ff <= 3'h0;
         byte_cnt_ff <= 2'h0;
         serial_data_out_o <= 1'b0;
         serial_data_out_oe_n_o <= 1'b1;
         if (!slp) begin
            hdr_ff <= 8'h00;
         end
      end else begin
         serial_data_out_oe_n_o <= 1'b0;
         if (sck_fall) begin
            rx_sr_ff <= rx_next;
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
         end
         // msb first, eight bits a unit
         if (byte_done) begin
            if (byte_cnt_ff != 2'h3) begin
               byte_cnt_ff <= byte_cnt_ff + 2'h1;
            end
            case (byte_cnt_ff)
               2'h0: begin
                  hdr_ff <= rx_next;
                  par_bad_ff <= rx_next[`HDR_RW_BIT] & par_fail(rx_next);
               end
               2'h1: d0_ff <= rx_next;
               2'h2: d1_ff <= rx_next;
               default: d1_ff <= d1_ff;
            endcase
         end
         // load read data after the header
         if (byte_done && byte_cnt_ff == 2'h0) begin
            tx_sr_ff <= reg_read(rx_next[`HDR_ADDR_MSB:`HDR_ADDR_LSB], hbc_ff, pwm_select_reg_ff,
               sc_ff, ss_val, rs_val, hbs_ff);
         end else if (sck_rise && byte_cnt_ff != 2'h0) begin
            serial_data_out_o <= tx_sr_ff[15];
            tx_sr_ff <= {tx_sr_ff[14:0], 1'b0};
         end
      end
   end

   // commit decision at slave select release
   wire [4:0] w_addr = hdr_ff[`HDR_ADDR_MSB:`HDR_ADDR_LSB];
   wire w_wide = (w_addr == `ADDR_BRIDGE_CTRL);
   wire w_full = w_wide ? (byte_cnt_ff >= 2'h3) : (byte_cnt_ff >= 2'h2);
   // commit only after slave select rise
   wire commit = ss_rise & slp & hdr_ff[`HDR_RW_BIT] & ~par_bad_ff & w_full;
   wire pe_set = byte_done & (byte_cnt_ff == 2'h0) & rx_next[`HDR_RW_BIT] &
      par_fail(rx_next);

   ////////////////////////////////////////////////////////////////////////////
   // control registers
   wire oc_any = |oc;
   wire oc_lo = |oc[2:0];
   wire oc_hi = |oc[5:3];
   wire scope_all = sc_ff[`SC_OC_SCOPE_BIT];
   reg [15:0] hbc_mask;
   reg [7:0] pwm_select_reg_mask;

   // over-current clear masks by channel group
   always @* begin
      hbc_mask = 16'hffff;
      pwm_select_reg_mask = 8'hff;
      if (scope_all && oc_any) begin
         hbc_mask = 16'h0000;
         pwm_select_reg_mask = 8'h00;
      end else if (!scope_all) begin
         if (oc_lo) begin
            hbc_mask[9:4] = 6'h00;
            pwm_select_reg_mask[4:2] = 3'h0;
         end
         if (oc_hi) begin
            hbc_mask[15:10] = 6'h00;
            pwm_select_reg_mask[7:5] = 3'h0;
         end
      end
   end

   wire wr_ok = commit & inhibit_pin & ~ot;

   // clears beat writes; an inhibit or overheat level keeps them clear
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hbc_ff <= `BRIDGE_CTRL_RST;
         pwm_select_reg_ff <= `PWM_SELECT_RST;
         sc_ff <= `SYS_CTRL_RST;
      end else if (!inhibit_pin || ot) begin
         hbc_ff <= `BRIDGE_CTRL_RST;
         pwm_select_reg_ff <= `PWM_SELECT_RST;
         if (commit && w_addr == `ADDR_SYS_CTRL) begin
            sc_ff <= d0_ff;
         end
      end else begin
         if (wr_ok && w_addr == `ADDR_BRIDGE_CTRL) begin
            hbc_ff <= hbc_merge(hbc_ff, {d0_ff, d1_ff}) & hbc_mask;
         end else begin
            hbc_ff <= hbc_ff & hbc_mask;
         end
         if (wr_ok && w_addr == `ADDR_PWM_SELECT) begin
            pwm_select_reg_ff <= {d0_ff[7:2], 2'h0} & pwm_select_reg_mask;
         end else begin
            pwm_select_reg_ff <= pwm_select_reg_ff & pwm_select_reg_mask;
         end
         if (commit && w_addr == `ADDR_SYS_CTRL) begin
            sc_ff <= d0_ff;
         end
      end
   end

   // status flags: hardware set wins over a clearing write of 0
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hbs_ff <= 6'h00;
         pe_ff <= 1'b0;
         ext_rst_ff <= 1'b0;
      end else begin
         if (commit && w_addr == `ADDR_BRIDGE_STATUS) begin
            hbs_ff <= (hbs_ff & d0_ff[5:0]) | oc;
         end else begin
            hbs_ff <= hbs_ff | oc;
         end
         if (pe_set) begin
            pe_ff <= 1'b1;
         end else if (commit && w_addr == `ADDR_SYS_STATUS && !d0_ff[`SS_PE_BIT]) begin
            pe_ff <= 1'b0;
         end
         if (ers_s_ff[1]) begin
            ext_rst_ff <= 1'b1;
         end else if (commit && w_addr == `ADDR_RESET_STATUS && !d0_ff[`RS_EXT_BIT]) begin
            ext_rst_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output path
   reg [11:0] req;
   integer c;

   always @* begin
      req = 12'h000;
      for (c = 0; c < 6; c = c + 1) begin
         req[2*c+1] = hbc_ff[`HBC_FIRST_BIT + 2*c + 1] & ~hbc_ff[`HBC_FIRST_BIT + 2*c];
         req[2*c] = ~hbc_ff[`HBC_FIRST_BIT + 2*c + 1] & hbc_ff[`HBC_FIRST_BIT + 2*c];
      end
   end

   wire [11:0] gated;

   dead_time_gate #(
      .N(12),
      .DEAD_CYCLES(DEAD_CYCLES),
      .CW(12)
   ) u_dead (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .req_i(req),
      .out_o(gated)
   );

   reg slp_d_ff;
   integer ch;

   // drive, freeze in sleep, or float in inhibit
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         high_side_on_o <= 6'h00;
         low_side_on_o <= 6'h00;
         bridge_output_hiz_o <= 6'h3f;
         slp_d_ff <= 1'b0;
      end else begin
         slp_d_ff <= slp;
         if (!inhibit_pin) begin
            high_side_on_o <= 6'h00;
            low_side_on_o <= 6'h00;
            bridge_output_hiz_o <= 6'h3f;
         end else if (!slp) begin
            if (slp_d_ff) begin
               bridge_output_hiz_o <= bridge_output_hiz_o | high_side_on_o;
               high_side_on_o <= 6'h00;
            end
         end else begin
            // control only when awake and enabled
            for (ch = 0; ch < 6; ch = ch + 1) begin
               high_side_on_o[ch] <= gated[2*ch+1] & ~oc[ch];
               // pwm routed to selected low sides
               low_side_on_o[ch] <= (gated[2*ch] | (pwm_select_reg_ff[`PWM_SELECT_REG_FIRST_BIT + ch] &
                  pwm_s_ff[1] & ~gated[2*ch+1])) & ~oc[ch];
               bridge_output_hiz_o[ch] <= ~(gated[2*ch+1] | gated[2*ch] |
                  pwm_select_reg_ff[`PWM_SELECT_REG_FIRST_BIT + ch]);
            end
         end
      end
   end
endmodule // spi_half_bridge_control

// ==== verif/host_serial_model.sv ====
// host model: serial master driving select, clock and data of the device
`timescale 1ns/10ps
module host_serial_model (
   input logic sdo_i,
   output logic ss_n_o = 1'b1,
   output logic sck_o = 1'b1,
   output logic sdi_o = 1'b0
);
   ////////////////////////////////////////////////////////////////////////////////
   // one frame of header plus nb data bytes; clock idles high and stands still between frames
   task automatic xfer(input [7:0] h, input [15:0] wd, input int nb, output logic [15:0] rd);
      logic [23:0] sh;
      sh = {h, (nb == 2) ? wd : {wd[7:0], 8'h00}};
      rd = 16'h0000;
      ss_n_o = 1'b0;
      for (int i = 0; i < 8 * (nb + 1); i++) begin
         sdi_o = sh[23 - i];
         #62.5 sck_o = 1'b0;
         if (i >= 8) rd = {rd[14:0], sdo_i};
         #62.5 sck_o = 1'b1;
      end
      #62.5 ss_n_o = 1'b1;
      // released line shows the inverse so a stale bit is never mistaken for data
      sdi_o = ~sdi_o;
      #250;
   endtask
endmodule // host_serial_model

// ==== verif/spi_half_bridge_control_monitor.sv ====
// concurrent checks on the half-bridge controller ports
`timescale 1ns/10ps
module spi_half_bridge_control_monitor #(
   parameter DEAD_CYCLES = 125
) (
   input logic clk_sys_i,
   input logic reset_n_i,
   input logic sleep_control_pin_i,
   input logic inhibit_pin_i,
   input logic pwm_input_pin_i,
   input logic overheat_i,
   input logic [5:0] overcurrent_i,
   input logic ext_reset_seen_i,
   input logic slave_select_input_n_i,
   input logic serial_clock_input_i,
   input logic serial_data_in_i,
   input logic serial_data_out_o,
   input logic serial_data_out_oe_n_o,
   input logic [5:0] high_side_on_o,
   input logic [5:0] low_side_on_o,
   input logic [5:0] bridge_output_hiz_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   ////////////////////////////////////////////////////////////////////////////////
   // windows of 5 or 6 samples cover the 2-stage input sync plus the output flop
   chk_pair_excl: assert property ((high_side_on_o & low_side_on_o) == 6'h00)
      else $error("both switches of a channel on");
   chk_inhibit_off: assert property (!inhibit_pin_i [*5] |->
      high_side_on_o == 6'h00 && low_side_on_o == 6'h00 && bridge_output_hiz_o == 6'h3f)
      else $error("outputs not off and floating under inhibit");
   chk_oc_channel_off: assert property (
      (sleep_control_pin_i && overcurrent_i != 6'h00 && $stable(overcurrent_i)) [*5] |->
      ((high_side_on_o | low_side_on_o) & overcurrent_i) == 6'h00)
      else $error("over-current channel still driven");
   // dead time of at least 3 cycles keeps a committed turn-on away for 6 samples
   chk_dead_time: assert property ($rose(slave_select_input_n_i) |=>
      ((high_side_on_o & ~$past(high_side_on_o)) == 6'h00) [*6])
      else $error("high side turned on without dead time");
   chk_sleep_hold: assert property ((!sleep_control_pin_i && inhibit_pin_i) [*6] |->
      $stable(low_side_on_o) && high_side_on_o == 6'h00)
      else $error("outputs not held in sleep");
   chk_sleep_hiz: assert property (
      $fell(sleep_control_pin_i) && inhibit_pin_i ##1
      (!sleep_control_pin_i && inhibit_pin_i) [*5] |->
      bridge_output_hiz_o == ($past(bridge_output_hiz_o, 3) | $past(high_side_on_o, 3)))
      else $error("floating set does not match high sides at sleep entry");
   chk_oe_idle: assert property (slave_select_input_n_i [*5] |-> serial_data_out_oe_n_o)
      else $error("data out driven while deselected");
   chk_oe_sleep: assert property (!sleep_control_pin_i [*5] |-> serial_data_out_oe_n_o)
      else $error("data out driven in sleep");
   chk_oe_drive: assert property (
      (!slave_select_input_n_i && sleep_control_pin_i) [*5] |-> !serial_data_out_oe_n_o)
      else $error("data out not driven in frame");
endmodule // spi_half_bridge_control_monitor

bind spi_half_bridge_control spi_half_bridge_control_monitor #(.DEAD_CYCLES(DEAD_CYCLES)) mon (
   .clk_sys_i, .reset_n_i, .sleep_control_pin_i, .inhibit_pin_i, .pwm_input_pin_i,
   .overheat_i, .overcurrent_i, .ext_reset_seen_i, .slave_select_input_n_i,
   .serial_clock_input_i, .serial_data_in_i, .serial_data_out_o, .serial_data_out_oe_n_o,
   .high_side_on_o, .low_side_on_o, .bridge_output_hiz_o);

// ==== verif/tb_spi_half_bridge_control.sv ====
// testbench: host frames program registers, bridge pins and read-back checked
`timescale 1ns/10ps
`include "hb_ctrl_map.vh"
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED %0t %s", $time, m); end end
module tb_spi_half_bridge_control;
   logic clk_sys_i = 1'b0, reset_n_i = 1'b0, sleep_control_pin_i = 1'b1, inhibit_pin_i = 1'b1;
   logic pwm_input_pin_i = 1'b0, overheat_i = 1'b0, ext_reset_seen_i = 1'b0;
   logic [5:0] overcurrent_i = 6'h00;
   wire slave_select_input_n_i, serial_clock_input_i, serial_data_in_i;
   wire serial_data_out_o, serial_data_out_oe_n_o;
   wire [5:0] high_side_on_o, low_side_on_o, bridge_output_hiz_o;
   int err_total = 0, n_compared = 0;
   logic [15:0] rdv;
   localparam [4:0] a_bc = `ADDR_BRIDGE_CTRL, a_pw = `ADDR_PWM_SELECT, a_st = `ADDR_SYS_STATUS;
   localparam [4:0] a_bst = `ADDR_BRIDGE_STATUS, a_cf = `ADDR_SYS_CTRL;
   localparam [4:0] a_rs = `ADDR_RESET_STATUS;
   always #4 clk_sys_i = ~clk_sys_i;
   spi_half_bridge_control #(.DEAD_CYCLES(4)) dut (.clk_sys_i, .reset_n_i,
      .sleep_control_pin_i, .inhibit_pin_i, .pwm_input_pin_i, .overheat_i, .overcurrent_i,
      .ext_reset_seen_i, .slave_select_input_n_i, .serial_clock_input_i, .serial_data_in_i,
      .serial_data_out_o, .serial_data_out_oe_n_o, .high_side_on_o, .low_side_on_o,
      .bridge_output_hiz_o);
   host_serial_model host (.sdo_i(serial_data_out_o), .ss_n_o(slave_select_input_n_i),
      .sck_o(serial_clock_input_i), .sdi_o(serial_data_in_i));
   ////////////////////////////////////////////////////////////////////////////////
   task tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   function automatic [7:0] hdr(input rw, input [4:0] a, input good);
      hdr = {rw, a, ^{rw, a} ^ !good, 1'b0};
   endfunction
   // control register takes two bytes, all others one
   task automatic wr(input [4:0] a, input [15:0] d, input good);
      host.xfer(hdr(1'b1, a, good), d, (a == a_bc) ? 2 : 1, rdv);
      tick(20);
   endtask
   // reads carry a wrong parity bit on purpose: it must not matter for reads
   task automatic rd(input [4:0] a, input [15:0] e, input string m);
      host.xfer(hdr(1'b0, a, 1'b0), 16'h0000, (a == a_bc) ? 2 : 1, rdv);
      `CHK(rdv, e, m)
   endtask
   // pins: {sleep, inhibit, pwm, overheat}
   task pins(input [5:0] o, input [3:0] p);
      tick(1);
      overcurrent_i <= o;
      {sleep_control_pin_i, inhibit_pin_i, pwm_input_pin_i, overheat_i} <= p;
      tick(20);
   endtask
   task automatic outs(input [5:0] h, input [5:0] l, input [5:0] z, input string m);
      `CHK(high_side_on_o, h, m)
      `CHK(low_side_on_o, l, m)
      `CHK(bridge_output_hiz_o, z, m)
   endtask
   task done(input string s);
      $display("test %s finished", s);
   endtask
   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // watchdog: a hang counts as a mismatch
   initial begin
      #700000;
      err_total++;
      $display("CHECK FAILED %0t timeout", $time);
      print_verdict;
   end
   initial begin
      tick(4);
      outs(6'h00, 6'h00, 6'h3f, "reset outputs");
      `CHK(serial_data_out_oe_n_o, 1'b1, "reset output enable")
      reset_n_i <= 1'b1;
      tick(4);
      wr(a_cf, 16'h0000, 1'b1);
      wr(a_bc, 16'h0420, 1'b1);
      outs(6'h01, 6'h08, 6'h36, "commit drives pins");
      rd(a_bc, 16'h0420, "control readback");
      done("write and read");
      wr(a_bc, 16'h04b0, 1'b1);
      outs(6'h03, 6'h08, 6'h34, "prohibited pair");
      rd(a_bc, 16'h04a0, "pair kept");
      wr(a_bc, 16'h0000, 1'b0);
      rd(a_st, 16'h0002, "parity flag");
      rd(a_bc, 16'h04a0, "bad parity write dropped");
      wr(a_st, 16'h0000, 1'b1);
      done("pair and parity");
      wr(a_pw, 16'h0010, 1'b1);
      pins(6'h00, 4'he);
      outs(6'h03, 6'h0c, 6'h30, "pwm high");
      pins(6'h00, 4'hc);
      outs(6'h03, 6'h08, 6'h30, "pwm low");
      done("pwm routing");
      pins(6'h01, 4'hc);
      outs(6'h00, 6'h08, 6'h37, "group one off");
      rd(a_bc, 16'h0400, "control bits 4-9 cleared");
      rd(a_pw, 16'h0000, "select bits 2-4 cleared");
      rd(a_st, 16'h0040, "group flag");
      rd(a_bst, 16'h0001, "channel flag");
      pins(6'h00, 4'hc);
      wr(a_bst, 16'h0000, 1'b1);
      wr(a_bc, 16'h0420, 1'b1);
      pins(6'h10, 4'hc);
      outs(6'h01, 6'h00, 6'h3e, "group two off");
      rd(a_bc, 16'h0020, "control bits 10-15 cleared");
      pins(6'h00, 4'hc);
      wr(a_bst, 16'h0000, 1'b1);
      wr(a_cf, 16'h0001, 1'b1);
      wr(a_bc, 16'h0420, 1'b1);
      pins(6'h01, 4'hc);
      outs(6'h00, 6'h00, 6'h3f, "all off");
      rd(a_bc, 16'h0000, "whole clear");
      pins(6'h00, 4'hc);
      wr(a_bst, 16'h0000, 1'b1);
      wr(a_cf, 16'h0000, 1'b1);
      done("over-current");
      wr(a_bc, 16'h0420, 1'b1);
      pins(6'h00, 4'h4);
      outs(6'h00, 6'h08, 6'h37, "sleep hold");
      wr(a_bc, 16'h0000, 1'b1);
      pins(6'h00, 4'hc);
      outs(6'h01, 6'h08, 6'h36, "wake");
      rd(a_bc, 16'h0420, "sleep frame ignored");
      done("sleep");
      wr(a_pw, 16'h0020, 1'b1);
      pins(6'h00, 4'h8);
      tick(1250);
      outs(6'h00, 6'h00, 6'h3f, "inhibit off");
      wr(a_bc, 16'h0080, 1'b1);
      pins(6'h00, 4'hc);
      rd(a_bc, 16'h0000, "control cleared");
      rd(a_pw, 16'h0000, "select cleared");
      done("inhibit");
      wr(a_bc, 16'h0020, 1'b1);
      pins(6'h00, 4'hd);
      rd(a_st, 16'h0004, "overheat flag");
      wr(a_bc, 16'h0080, 1'b1);
      pins(6'h00, 4'hc);
      rd(a_bc, 16'h0000, "overheat write ignored");
      done("overheat");
      // sticky external reset flag: set by the pin, cleared by writing 0
      tick(1);
      ext_reset_seen_i <= 1'b1;
      tick(4);
      ext_reset_seen_i <= 1'b0;
      tick(4);
      rd(a_rs, 16'h0040, "external reset flag");
      wr(a_rs, 16'h0000, 1'b1);
      rd(a_rs, 16'h0000, "external reset flag cleared");
      done("reset status");
      print_verdict;
   end
endmodule // tb_spi_half_bridge_control
